// >>> tb/spcr_far_end.sv
// Remote asynchronous transceiver and synchronous clock master model facing the serial port pins
`default_nettype none
module spcr_far_end #(parameter int BIT_NS = 160) (
  output logic to_dut,
  output logic clk_to_dut,
  input wire logic from_dut
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle line is high, like a pulled-up link
  initial to_dut = 1'b1;
  // Link clock rests low between slave-mode characters
  initial clk_to_dut = 1'b0;
  // Frame is start, data LSB first, optional ninth, then stop
  task automatic send(input logic [8:0] v, input logic nine, input logic bad);
    #3 to_dut = 1'b0;
    #BIT_NS;
    for (int i = 0; i < 9; i++) begin
      if (i < 8 || nine) begin
        to_dut = v[i];
        #BIT_NS;
      end
    end
    to_dut = ~bad; // Low stop bit makes a framing fault
    #BIT_NS;
    to_dut = 1'b1;
    #BIT_NS;
  endtask
  // Samples mid-bit; all ones come back if no start edge shows up
  task automatic capture(output logic [8:0] v, input logic nine);
    int n;
    v = 9'h1ff;
    n = 0;
    while (from_dut !== 1'b0 && n < 2000) begin
      #10;
      n++;
    end
    if (n < 2000) begin
      #(BIT_NS + BIT_NS / 2);
      for (int i = 0; i < 9; i++) begin
        if (i < 8 || nine) begin
          v[i] = from_dut;
          #BIT_NS;
        end
      end
      if (!nine) v[8] = 1'b0;
    end
  endtask
  // Clock master feed, 80 ns period; data moves 20 ns after each fall
  task automatic clock_in(input logic [7:0] v);
    #3;
    for (int i = 0; i < 8; i++) begin
      to_dut = v[i];
      #20 clk_to_dut = 1'b1;
      #40 clk_to_dut = 1'b0;
      #20;
    end
  endtask
endmodule // spcr_far_end
`default_nettype wire

// >>> tb/spcr_top_tb_top.sv
// Register-level bench for the serial port with a remote transceiver
`default_nettype none
module spcr_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  spcr_pkg::spcr_bus_t bus = '0;
  logic [7:0] rdata;
  logic rx_line, tx_pin, tx_oe, irq, lck, dt_out, dt_oe;
  logic [8:0] got;
  int err_count = 0;
  int total_checks = 0;
  // 100 MHz system clock
  always #5 clk = ~clk;
  spcr_top dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .receive_data_pin_in(rx_line), .receive_data_pin_out(dt_out),
    .receive_data_pin_oe(dt_oe), .transmit_clock_pin_in(lck),
    .transmit_clock_pin_out(tx_pin), .transmit_clock_pin_oe(tx_oe),
    .receive_interrupt_flag(irq));
  spcr_far_end #(.BIT_NS(160)) far (.to_dut(rx_line), .clk_to_dut(lck),
    .from_dut(tx_pin));
  task automatic tally_and_finish();
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask
  // Read data is only valid in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk({1'b0, rdata}, {1'b0, exp});
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      err_count++;
      tally_and_finish();
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
  endtask
  // Main sequence; divisor 3 with fast settings gives 16 clocks per bit
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd(3'h0, 8'h02);
    rd(3'h1, 8'h00);
    rd(3'h2, 8'h40);
    rd(3'h7, 8'h00);
    wr(3'h2, 8'h3c);
    rd(3'h2, 8'h58);
    wr(3'h3, 8'h03);
    wr(3'h4, 8'h00);
    wr(3'h0, 8'h24);
    wr(3'h1, 8'h90);
    settle();
    chk({8'h00, tx_pin}, 9'h000);
    chk({8'h00, tx_oe}, 9'h001);
    wr(3'h2, 8'h08);
    settle(); // Let the idle level follow the new polarity first
    fork
      far.capture(got, 1'b0);
      begin
        wr(3'h5, 8'ha5);
        rd(3'h0, 8'h24);
      end
    join
    chk(got, 9'h0a5);
    // Capture returns mid stop bit; a data write now would be dropped
    repeat (10) @(posedge clk);
    wr(3'h0, 8'h65);
    fork
      far.capture(got, 1'b1);
      wr(3'h5, 8'h3c);
    join
    chk(got, 9'h13c);
    repeat (30) @(posedge clk);
    rd(3'h0, 8'h67);
    wr(3'h0, 8'h2c);
    fork
      far.capture(got, 1'b0);
      wr(3'h5, 8'h55);
    join
    chk(got, 9'h000);
    repeat (400) @(posedge clk);
    rd(3'h0, 8'h26);
    fork
      far.send(9'h05a, 1'b0, 1'b0);
      begin
        repeat (40) @(posedge clk);
        rd(3'h2, 8'h08);
      end
    join
    wait_irq();
    rd(3'h1, 8'h90);
    rd(3'h6, 8'h5a);
    settle();
    chk({8'h00, irq}, 9'h000);
    rd(3'h2, 8'h48);
    // Third frame unread while two are held must overrun
    for (int i = 1; i < 4; i++) far.send(9'(i * 17), 1'b0, 1'b0);
    settle();
    rd(3'h1, 8'h92);
    rd(3'h6, 8'h11);
    rd(3'h6, 8'h22);
    wr(3'h1, 8'h80);
    rd(3'h1, 8'h80);
    wr(3'h1, 8'h90);
    far.send(9'h077, 1'b0, 1'b1);
    wait_irq();
    rd(3'h1, 8'h94);
    rd(3'h6, 8'h77);
    rd(3'h1, 8'h90);
    wr(3'h1, 8'hd8);
    far.send(9'h044, 1'b1, 1'b0);
    settle();
    chk({8'h00, irq}, 9'h000);
    far.send(9'h155, 1'b1, 1'b0);
    wait_irq();
    rd(3'h1, 8'hd9);
    rd(3'h6, 8'h55);
    wr(3'h1, 8'h90);
    // Wake-up: one falling edge flags, nothing is received
    wr(3'h2, 8'h0a);
    far.send(9'h000, 1'b0, 1'b0);
    wait_irq();
    rd(3'h2, 8'h48);
    rd(3'h6, 8'h00);
    settle();
    chk({8'h00, irq}, 9'h000);
    // Autorate on 0x55: 128 clocks over 32 gives divisor 3
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h09);
    far.send(9'h055, 1'b0, 1'b0);
    rd(3'h3, 8'h03);
    rd(3'h2, 8'h48);
    // Synchronous master drives the clock pin, slave releases it
    wr(3'h0, 8'h90);
    settle();
    chk({8'h00, tx_oe}, 9'h001);
    wr(3'h0, 8'h10);
    settle();
    chk({8'h00, tx_oe}, 9'h000);
    wr(3'h1, 8'h00);
    wr(3'h0, 8'h24);
    settle();
    chk({8'h00, tx_oe}, 9'h000);
    // Synchronous slave receive on the far clock, falling edge
    wr(3'h0, 8'h10);
    wr(3'h1, 8'h90);
    far.clock_in(8'hc3);
    wait_irq();
    rd(3'h6, 8'hc3);
    // Synchronous master transmit drives the data pin
    wr(3'h1, 8'h80);
    wr(3'h0, 8'hb0);
    wr(3'h5, 8'h01);
    settle();
    chk({8'h00, dt_oe}, 9'h001);
    chk({8'h00, dt_out}, 9'h001);
    tally_and_finish();
  end
endmodule // spcr_top_tb_top
`default_nettype wire

// >>> verilog/spcr_pkg.sv
// Types shared by the serial port files
`default_nettype none
package spcr_pkg;
  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } spcr_bus_t;
  typedef struct packed {
    logic framing_error_flag;
    logic b9;
    logic [7:0] data;
  } spcr_ent_t;
  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_BITS, RX_STOP
  } spcr_rx_st_t;
endpackage
`default_nettype wire

// >>> verilog/spcr_rate_timer.sv
// Free-running rate timer producing one tick per divisor period
`default_nettype none
module spcr_rate_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic sixteen,
  input wire logic [15:0] divisor,
  output logic tick
);
  logic [15:0] count;
  logic [15:0] limit;

  // Upper byte only counts in sixteen-bit mode
  assign limit = sixteen ? divisor : {8'h00, divisor[7:0]};

  // Compare with >= so a smaller new limit never runs the count away
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (clear) begin
      count <= 16'h0000;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= 16'h0000;
      tick <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      tick <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_div_clr;
    clear |=> count == 16'h0000 && !tick;
  endproperty
  a_div_clr: assert property (p_div_clr)
    else $error("rate timer not cleared");

  property p_tick_gap;
    tick && !clear && limit != 16'h0000 |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("rate ticks too close");
endmodule // spcr_rate_timer
`default_nettype wire

// >>> verilog/spcr_regs.svh
// Register map, field positions, reset values and timing counts
// Operation
// - Rate timer is 8-bit by default, 16-bit when sixteen-bit select set.
// - Divisor pair sets timer period; sync mode ignores high-speed select.
// - Writing either divisor half clears the rate timer at once.
// - Sync mode: clock source select makes master driving clock, else slave.
// - Nine-bit transmit select appends the transmit ninth bit to each char.
// - Transmit enable starts sending; sync receive enables take precedence.
// - Clocked-mode select picks synchronous when set, asynchronous when clear.
// - Async break-send sends a break next; hardware clears it when done.
// - Shifter empty flag reads 1 when idle, 0 when busy; resets to 1.
// - Port enable claims both pins; clearing it holds the port in reset.
// - Sync master single receive takes one character, then self-clears.
// - Continuous receive enables async receiver; in sync overrides single.
// - Nine-bit async address detect accepts only ninth-bit-set characters.
// - Framing error shows head character status; advances on data read.
// - Overrun flag stays set until continuous receive enable is cleared.
// - Receive ninth bit shows ninth bit of head character; no parity logic.
// - Async autorate overflow flag sets when the measuring counter overflows.
// - Async receive idle reads 1 when idle, 0 from start bit to end.
// - Async polarity inverts transmit data; sync picks the clocking edge.
// - Wake-up waits for a receive falling edge, flags it, then self-clears.
// - Async autorate enable measures the rate; hardware clears it on finish.
// - Rate control bits 5 and 2 read as 0 and ignore writes.
// - Baud is clock over 64, 16 or 4 times divisor plus one.
// - Two-character receive buffer; third character flags overrun, stops.
`ifndef SPCR_REGS_SVH
`define SPCR_REGS_SVH
`define SPCR_A_TXC 3'h0
`define SPCR_A_RXC 3'h1
`define SPCR_A_RTC 3'h2
`define SPCR_A_DVL 3'h3
`define SPCR_A_DVH 3'h4
`define SPCR_A_TXD 3'h5
`define SPCR_A_RXD 3'h6
`define SPCR_TXC_CLOCK_SOURCE_SELECT 7
`define SPCR_TXC_TX9 6
`define SPCR_TXC_TRANSMIT_ENABLE 5
`define SPCR_TXC_SYNC 4
`define SPCR_TXC_BRK 3
`define SPCR_TXC_HSR 2
`define SPCR_TXC_T9D 0
`define SPCR_RXC_PEN 7
`define SPCR_RXC_RX9 6
`define SPCR_RXC_SRE 5
`define SPCR_RXC_CRE 4
`define SPCR_RXC_ADE 3
`define SPCR_RTC_POL 4
`define SPCR_RTC_S16 3
`define SPCR_RTC_WUE 1
`define SPCR_RTC_ABE 0
`define SPCR_TXC_RST 8'h00
`define SPCR_RXC_RST 8'h00
`define SPCR_RTC_RST 8'h00
`define SPCR_RTC_WMASK 8'h1b
`define SPCR_DIV_RST 8'h00
`define SPCR_PM_64 6'h3f
`define SPCR_PM_16 6'h0f
`define SPCR_PM_4 6'h03
`define SPCR_BRK_FRAME 14'h2000
`define SPCR_BRK_BITS 4'he
`define SPCR_AB_FALLS 3'h4
`endif

// >>> verilog/spcr_top.sv
// Serial port control, status, receive buffer and rate selection
//
// The address-and-strobe port and the register addresses were left to the implementer.
`default_nettype none
`include "spcr_regs.svh"
module spcr_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire spcr_pkg::spcr_bus_t bus,
  output logic [7:0] rdata,
  input wire logic receive_data_pin_in,
  output logic receive_data_pin_out,
  output logic receive_data_pin_oe,
  input wire logic transmit_clock_pin_in,
  output logic transmit_clock_pin_out,
  output logic transmit_clock_pin_oe,
  output logic receive_interrupt_flag
);
  logic [7:0] tx_ctl, rx_ctl, rate_ctl, div_lo, div_hi;
  logic port_en, srst, sync_m, master, pol, cre, sre, rx9;
  logic wr_txc, wr_rxc, wr_rtc, wr_txd, rd_rxd, div_wr;
  logic tick;
  logic [5:0] pmax;
  logic [3:0] ab_sh;
  logic [2:0] rx_s;
  logic [1:0] ck_s;
  logic rx_fall;
  logic sck, sck_ph, sck_d, sck_now, act, lau;
  logic tx_run, tx_brk, tx_seen, tx_req, brk_done;
  logic [13:0] tx_sh;
  logic [3:0] tx_left;
  logic [5:0] tx_pc;
  spcr_pkg::spcr_rx_st_t st;
  logic [8:0] rx_sh;
  logic [3:0] rx_left, nb;
  logic [5:0] rx_pc;
  logic rx_done, rx_fe, a_rx_en, sy_rx_want, sy_rx_en;
  spcr_pkg::spcr_ent_t fifo [2];
  spcr_pkg::spcr_ent_t new_ent, head_ent;
  logic [1:0] cnt;
  logic head, wp, push, push_ok, pop, accept;
  logic ovr, wake_flg, wake_hit;
  logic abe_act, ab_run, ab_load, ab_ovf;
  logic [23:0] ab_cnt, ab_q;
  logic [2:0] ab_edg;
  logic [15:0] ab_res;

  // Field aliases; the mode bit steers every mode-dependent field
  assign port_en = rx_ctl[`SPCR_RXC_PEN];
  assign srst = !port_en;
  assign sync_m = tx_ctl[`SPCR_TXC_SYNC];
  assign master = sync_m && tx_ctl[`SPCR_TXC_CLOCK_SOURCE_SELECT];
  assign pol = rate_ctl[`SPCR_RTC_POL];
  assign cre = rx_ctl[`SPCR_RXC_CRE];
  assign sre = rx_ctl[`SPCR_RXC_SRE];
  assign rx9 = rx_ctl[`SPCR_RXC_RX9];
  assign nb = rx9 ? 4'h9 : 4'h8;

  // Address decode
  assign wr_txc = bus.wr && bus.addr == `SPCR_A_TXC;
  assign wr_rxc = bus.wr && bus.addr == `SPCR_A_RXC;
  assign wr_rtc = bus.wr && bus.addr == `SPCR_A_RTC;
  assign wr_txd = bus.wr && bus.addr == `SPCR_A_TXD;
  assign rd_rxd = bus.rd && bus.addr == `SPCR_A_RXD;
  assign div_wr = (bus.wr && (bus.addr == `SPCR_A_DVL ||
                  bus.addr == `SPCR_A_DVH)) || ab_load;

  // Transmit control; hardware ends a break unless software rewrites
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_ctl <= `SPCR_TXC_RST;
    end else if (wr_txc) begin
      tx_ctl <= bus.wdata;
    end else if (brk_done) begin
      tx_ctl[`SPCR_TXC_BRK] <= 1'b0;
    end
  end

  // Receive control; single receive drops after its character
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_ctl <= `SPCR_RXC_RST;
    end else if (wr_rxc) begin
      rx_ctl <= bus.wdata;
    end else if (rx_done && master && !cre) begin
      rx_ctl[`SPCR_RXC_SRE] <= 1'b0;
    end
  end

  // Rate control; unimplemented bits never store
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rate_ctl <= `SPCR_RTC_RST;
    end else if (wr_rtc) begin
      rate_ctl <= bus.wdata & `SPCR_RTC_WMASK;
    end else begin
      if (wake_hit) rate_ctl[`SPCR_RTC_WUE] <= 1'b0;
      if (ab_load) rate_ctl[`SPCR_RTC_ABE] <= 1'b0;
    end
  end

  // Divisor pair; a measured rate lands here too
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_lo <= `SPCR_DIV_RST;
      div_hi <= `SPCR_DIV_RST;
    end else if (bus.wr && bus.addr == `SPCR_A_DVL) begin
      div_lo <= bus.wdata;
    end else if (bus.wr && bus.addr == `SPCR_A_DVH) begin
      div_hi <= bus.wdata;
    end else if (ab_load) begin
      {div_hi, div_lo} <= ab_res;
    end
  end

  spcr_rate_timer u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .clear(div_wr || srst),
    .sixteen(rate_ctl[`SPCR_RTC_S16]),
    .divisor({div_hi, div_lo}),
    .tick(tick)
  );

  // Ticks per bit; sync ignores high speed select
  always_comb begin
    pmax = `SPCR_PM_16;
    ab_sh = 4'h7;
    if (sync_m) begin
      pmax = `SPCR_PM_4;
      ab_sh = 4'h5;
    end else begin
      case ({rate_ctl[`SPCR_RTC_S16], tx_ctl[`SPCR_TXC_HSR]})
        2'b00: begin
          pmax = `SPCR_PM_64;
          ab_sh = 4'h9;
        end
        2'b11: begin
          pmax = `SPCR_PM_4;
          ab_sh = 4'h5;
        end
        default: begin
          pmax = `SPCR_PM_16;
          ab_sh = 4'h7;
        end
      endcase
    end
  end

  // Pin synchronisers; stage 0 feeds only stage 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s <= 3'h7;
      ck_s <= 2'h0;
    end else begin
      rx_s <= {rx_s[1:0], receive_data_pin_in};
      ck_s <= {ck_s[0], transmit_clock_pin_in};
    end
  end
  assign rx_fall = rx_s[2] && !rx_s[1];

  // Master clock toggles every two ticks, so one bit is four ticks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sck <= 1'b0;
      sck_ph <= 1'b0;
    end else if (!master || !(tx_run || sy_rx_en)) begin
      sck <= 1'b0;
      sck_ph <= 1'b0;
    end else if (tick) begin
      sck_ph <= !sck_ph;
      if (sck_ph) sck <= !sck;
    end
  end

  // Edge finder for either clock source
  assign sck_now = master ? sck : ck_s[1];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sck_d <= 1'b0;
    else sck_d <= sck_now;
  end
  assign act = sync_m && (pol ? (sck_now && !sck_d)
                              : (!sck_now && sck_d));
  assign lau = sync_m && (pol ? (!sck_now && sck_d)
                              : (sck_now && !sck_d));

  // Sync receive requests win over transmit
  assign sy_rx_want = sync_m && (cre || (sre && master));
  assign sy_rx_en = sy_rx_want && !ovr && !tx_run;
  assign tx_req = wr_txd && port_en && tx_ctl[`SPCR_TXC_TRANSMIT_ENABLE] &&
                  !tx_run && !sy_rx_want;
  assign brk_done = tx_run && tx_brk && tick && tx_pc == pmax &&
                    tx_left == 4'h1;

  // Transmit shifter; a write while busy is dropped, no holding stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_run <= 1'b0;
      tx_brk <= 1'b0;
      tx_seen <= 1'b0;
      tx_sh <= 14'h3fff;
      tx_left <= 4'h0;
      tx_pc <= 6'h00;
    end else if (srst) begin
      tx_run <= 1'b0;
      tx_brk <= 1'b0;
      tx_sh <= 14'h3fff;
    end else if (tx_req) begin
      tx_run <= 1'b1;
      tx_pc <= 6'h00;
      tx_seen <= 1'b0;
      tx_brk <= !sync_m && tx_ctl[`SPCR_TXC_BRK];
      if (sync_m) begin
        tx_sh <= {5'h1f, tx_ctl[`SPCR_TXC_T9D], bus.wdata};
        tx_left <= tx_ctl[`SPCR_TXC_TX9] ? 4'h9 : 4'h8;
      end else if (tx_ctl[`SPCR_TXC_BRK]) begin
        tx_sh <= `SPCR_BRK_FRAME;
        tx_left <= `SPCR_BRK_BITS;
      end else if (tx_ctl[`SPCR_TXC_TX9]) begin
        tx_sh <= {4'hf, tx_ctl[`SPCR_TXC_T9D], bus.wdata, 1'b0};
        tx_left <= 4'hb;
      end else begin
        tx_sh <= {5'h1f, bus.wdata, 1'b0};
        tx_left <= 4'ha;
      end
    end else if (tx_run && sync_m) begin
      if (act) begin
        tx_left <= tx_left - 4'h1;
        tx_seen <= 1'b1;
      end else if (lau && tx_seen) begin
        tx_seen <= 1'b0;
        tx_sh <= {1'b1, tx_sh[13:1]};
        if (tx_left == 4'h0) tx_run <= 1'b0;
      end
    end else if (tx_run && tick) begin
      if (tx_pc == pmax) begin
        tx_pc <= 6'h00;
        tx_sh <= {1'b1, tx_sh[13:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h1) tx_run <= 1'b0;
      end else begin
        tx_pc <= tx_pc + 6'h01;
      end
    end
  end

  // Pin drivers; a disabled port releases both pins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      transmit_clock_pin_out <= 1'b0;
      transmit_clock_pin_oe <= 1'b0;
      receive_data_pin_out <= 1'b0;
      receive_data_pin_oe <= 1'b0;
    end else if (srst) begin
      transmit_clock_pin_oe <= 1'b0;
      receive_data_pin_oe <= 1'b0;
    end else if (!sync_m) begin
      transmit_clock_pin_out <= (tx_run ? tx_sh[0] : 1'b1) ^ pol;
      transmit_clock_pin_oe <= 1'b1;
      receive_data_pin_oe <= 1'b0;
    end else begin
      transmit_clock_pin_out <= sck;
      transmit_clock_pin_oe <= master;
      receive_data_pin_out <= tx_sh[0];
      receive_data_pin_oe <= tx_run;
    end
  end

  // Async receive waits while overrun, wake-up or measuring
  assign a_rx_en = !sync_m && cre && !ovr &&
                   !rate_ctl[`SPCR_RTC_WUE] && !abe_act;
  assign wake_hit = port_en && !sync_m && rate_ctl[`SPCR_RTC_WUE] &&
                    rx_fall;

  // Receive engine; async samples mid-bit, sync on the active edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= spcr_pkg::RX_IDLE;
      rx_sh <= 9'h000;
      rx_left <= 4'h0;
      rx_pc <= 6'h00;
      rx_done <= 1'b0;
      rx_fe <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      if (srst) begin
        st <= spcr_pkg::RX_IDLE;
        rx_left <= nb; // No stale bit count survives a disable
      end else if (sync_m) begin
        st <= spcr_pkg::RX_IDLE;
        if (!sy_rx_en) begin
          rx_left <= nb;
        end else if (act) begin
          rx_sh <= {rx_s[1], rx_sh[8:1]};
          if (rx_left == 4'h1) begin
            rx_done <= 1'b1;
            rx_fe <= 1'b0;
            rx_left <= nb;
          end else begin
            rx_left <= rx_left - 4'h1;
          end
        end
      end else begin
        case (st)
          spcr_pkg::RX_IDLE: if (a_rx_en && rx_fall) begin
            st <= spcr_pkg::RX_START;
            rx_pc <= 6'h00;
            rx_left <= nb;
          end
          spcr_pkg::RX_START: if (tick) begin
            if (rx_pc == (pmax >> 1)) begin
              rx_pc <= 6'h00;
              st <= rx_s[1] ? spcr_pkg::RX_IDLE : spcr_pkg::RX_BITS;
            end else begin
              rx_pc <= rx_pc + 6'h01;
            end
          end
          spcr_pkg::RX_BITS: if (tick) begin
            if (rx_pc == pmax) begin
              rx_pc <= 6'h00;
              rx_sh <= {rx_s[1], rx_sh[8:1]};
              rx_left <= rx_left - 4'h1;
              if (rx_left == 4'h1) st <= spcr_pkg::RX_STOP;
            end else begin
              rx_pc <= rx_pc + 6'h01;
            end
          end
          spcr_pkg::RX_STOP: if (tick) begin
            if (rx_pc == pmax) begin
              rx_fe <= !rx_s[1];
              rx_done <= 1'b1;
              st <= spcr_pkg::RX_IDLE;
            end else begin
              rx_pc <= rx_pc + 6'h01;
            end
          end
          default: st <= spcr_pkg::RX_IDLE;
        endcase
      end
    end
  end

  // Character packing; address mode drops ninth-bit-clear characters
  assign new_ent.framing_error_flag = rx_fe;
  assign new_ent.b9 = rx9 ? rx_sh[8] : 1'b0;
  assign new_ent.data = rx9 ? rx_sh[7:0] : rx_sh[8:1];
  assign accept = !(!sync_m && rx9 && rx_ctl[`SPCR_RXC_ADE] &&
                    !rx_sh[8]);
  assign push = rx_done && accept && port_en;
  assign pop = rd_rxd && cnt != 2'h0;
  assign push_ok = push && (cnt != 2'h2 || pop);
  assign wp = head ^ cnt[0];
  assign head_ent = (cnt != 2'h0) ? fifo[head] : '0;

  // Two-entry buffer storage
  for (genvar g = 0; g < 2; g++) begin : g_ent
    always_ff @(posedge clk) begin
      if (push_ok && wp == 1'(g)) fifo[g] <= new_ent;
    end
  end

  // Buffer pointers and overrun; a new overrun beats the clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 2'h0;
      head <= 1'b0;
      ovr <= 1'b0;
    end else if (srst) begin
      cnt <= 2'h0;
      head <= 1'b0;
      ovr <= 1'b0;
    end else begin
      cnt <= cnt + {1'b0, push_ok} - {1'b0, pop};
      if (pop) head <= !head;
      if (push && !push_ok) ovr <= 1'b1;
      else if (!cre) ovr <= 1'b0;
    end
  end

  // Wake event and receive flag; a wake edge wins over a read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_flg <= 1'b0;
      receive_interrupt_flag <= 1'b0;
    end else begin
      if (srst) wake_flg <= 1'b0;
      else if (wake_hit) wake_flg <= 1'b1;
      else if (rd_rxd) wake_flg <= 1'b0;
      receive_interrupt_flag <= port_en && (cnt != 2'h0 || wake_flg);
    end
  end

  // Rate measurement spans eight bit times of a 0x55 character
  assign abe_act = rate_ctl[`SPCR_RTC_ABE] && !sync_m && port_en;
  assign ab_q = ab_cnt >> ab_sh;
  assign ab_res = ab_q[15:0] - 16'h0001;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ab_run <= 1'b0;
      ab_cnt <= 24'h000000;
      ab_edg <= 3'h0;
      ab_load <= 1'b0;
      ab_ovf <= 1'b0;
    end else if (!abe_act) begin
      ab_run <= 1'b0;
      ab_edg <= 3'h0;
      ab_load <= 1'b0;
      ab_ovf <= 1'b0;
    end else begin
      ab_load <= 1'b0;
      if (!ab_run) begin
        if (rx_fall && !ab_load) begin
          ab_run <= 1'b1;
          ab_cnt <= 24'h000000;
          ab_edg <= 3'h0;
        end
      end else if (&ab_cnt) begin
        ab_ovf <= 1'b1;
      end else begin
        ab_cnt <= ab_cnt + 24'h000001;
        if (rx_fall) begin
          ab_edg <= ab_edg + 3'h1;
          if (ab_edg == `SPCR_AB_FALLS - 3'h1) begin
            ab_run <= 1'b0;
            ab_load <= 1'b1;
          end
        end
      end
    end
  end

  // Read port; data only in the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (!bus.rd) begin
      rdata <= 8'h00;
    end else begin
      case (bus.addr)
        `SPCR_A_TXC: rdata <= {tx_ctl[7:2], !tx_run, tx_ctl[0]};
        `SPCR_A_RXC: rdata <= {rx_ctl[7:3], head_ent.framing_error_flag, ovr,
                               head_ent.b9};
        `SPCR_A_RTC: rdata <= {ab_ovf, st == spcr_pkg::RX_IDLE, 1'b0,
                               rate_ctl[4:3], 1'b0, rate_ctl[1:0]};
        `SPCR_A_DVL: rdata <= div_lo;
        `SPCR_A_DVH: rdata <= div_hi;
        `SPCR_A_RXD: rdata <= head_ent.data;
        default: rdata <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_brk_clr;
    brk_done && !wr_txc |=> !tx_ctl[`SPCR_TXC_BRK];
  endproperty
  a_brk_clr: assert property (p_brk_clr)
    else $error("break bit not cleared");

  property p_ovr_set;
    port_en && push && cnt == 2'h2 && !pop |=> ovr && cnt == 2'h2;
  endproperty
  a_ovr_set: assert property (p_ovr_set)
    else $error("overrun not flagged");

  property p_ovr_clr;
    !cre && !push |=> !ovr;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr)
    else $error("overrun not cleared");

  property p_addr_drop;
    rx_done && !accept && !pop |=> $stable(cnt);
  endproperty
  a_addr_drop: assert property (p_addr_drop)
    else $error("address filter let character in");

  sequence s_wake;
    wake_hit && !wr_rtc && !rd_rxd ##1 port_en;
  endsequence
  property p_wake;
    s_wake |-> !rate_ctl[`SPCR_RTC_WUE] ##1 receive_interrupt_flag;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake-up sequence wrong");

  property p_disable;
    !port_en |=> !receive_data_pin_oe && !transmit_clock_pin_oe &&
                 !tx_run && cnt == 2'h0;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disabled port still active");

  property p_idle;
    st == spcr_pkg::RX_IDLE && port_en && a_rx_en && rx_fall
      |=> st == spcr_pkg::RX_START;
  endproperty
  a_idle: assert property (p_idle)
    else $error("start bit missed");

  property p_tx_start;
    tx_req |=> tx_run ##1 transmit_clock_pin_oe || receive_data_pin_oe;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("transmit did not start");
endmodule // spcr_top
`default_nettype wire
